/* core/scrs_cfg.svh */
// Offsets, field positions, reset values and writable masks of the serial clock select block
`ifndef SCRS_CFG_SVH
`define SCRS_CFG_SVH

// Register indices; byte address is four times the index
`define SCRS_IDX_PROTECT        12'h00A
`define SCRS_IDX_PCLK_SEL       12'h012
`define SCRS_IDX_MODE           12'h248
`define SCRS_IDX_TX_BUF         12'h24A
`define SCRS_IDX_CTRL_ONE       12'h24D
`define SCRS_IDX_RX_BUF         12'h24E
`define SCRS_IDX_CLK_SRC        12'h252
`define SCRS_IDX_INT_STAT       12'h300
`define SCRS_IDX_INT_MASK       12'h301

// Reset values
`define SCRS_RST_PCLK_SEL       8'h03
`define SCRS_RST_CLK_SRC        8'h00
`define SCRS_RST_PROTECT        8'h00
`define SCRS_RST_MODE           8'h00
`define SCRS_RST_CTRL_ONE       8'h00

// Field positions
`define SCRS_B_TIMER_RATE       0
`define SCRS_B_SERIAL_RATE      1
`define SCRS_B_CLKOUT_EXT       5
`define SCRS_B_LOW_SRC          2
`define SCRS_B_HIGH_SRC         3
`define SCRS_B_WR_EN            0
`define SCRS_B_PARITY_SEL       6
`define SCRS_B_RX_EN            2
`define SCRS_B_RX_FULL          3
`define SCRS_B_ABT              11
`define SCRS_B_OER              12
`define SCRS_B_FER              13
`define SCRS_B_PER              14
`define SCRS_B_SUM              15

// Writable masks of the clock registers; reserved bits stay zero
`define SCRS_PCLK_WMASK         8'h23
`define SCRS_CLK_SRC_WMASK      8'h0C

// Interrupt status bit positions
`define SCRS_I_RX               0
`define SCRS_I_OER              1
`define SCRS_I_FER              2
`define SCRS_I_PER              3
`define SCRS_I_ABT              4
`define SCRS_NUM_INT            5

`endif

/* core/scrs_pkg.sv */
// Types of the serial clock select and receive status block
package scrs_pkg;

    typedef enum logic [2:0] {
        MODE_OFF    = 3'h0,
        MODE_SYNC   = 3'h1,
        MODE_I2C    = 3'h2,
        MODE_UART7  = 3'h4,
        MODE_UART8  = 3'h5,
        MODE_UART9  = 3'h6
    } scrs_mode_t;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_PROTECT, SEL_PCLK, SEL_MODE, SEL_TX, SEL_CTRL,
        SEL_RX, SEL_CLK_SRC, SEL_ISTAT, SEL_IMASK
    } scrs_sel_t;

endpackage

/* core/scrs_core.sv */
// Serial clock select, protected clock register and receive buffer status logic
`timescale 1ns/100ps
`include "scrs_cfg.svh"

module scrs_core (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Receive shift register side
    input  wire logic        rx_done,
    input  wire logic [8:0]  rx_char,
    input  wire logic        rx_parity_bit,
    input  wire logic        rx_stop_ok,
    // Bus-mode arbitration
    input  wire logic        sda_pin,
    input  wire logic        sda_drive_level,
    input  wire logic        sda_sample,
    // Transmit path
    output logic [8:0]       tx_data,
    output logic             tx_load,
    // Clock and mode controls
    output logic             serial_clock_rate_sel,
    output logic             timer_clock_rate_sel,
    output logic             clock_output_extension,
    output logic             low_channels_clock_source_sel,
    output logic             high_channels_clock_source_sel,
    output logic [2:0]       mode_code,
    output logic             reception_enable,
    output logic             parity_odd_even_select,
    // Interrupt
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic scrs_pkg::scrs_sel_t decode(input logic [31:0] a);
        logic [11:0] idx;
        idx = a[13:2];
        if (a[31:14] != 18'h0 || a[1:0] != 2'h0) begin
            decode = scrs_pkg::SEL_NONE;
        end else begin
            case (idx)
                `SCRS_IDX_PROTECT:  decode = scrs_pkg::SEL_PROTECT;
                `SCRS_IDX_PCLK_SEL: decode = scrs_pkg::SEL_PCLK;
                `SCRS_IDX_MODE:     decode = scrs_pkg::SEL_MODE;
                `SCRS_IDX_TX_BUF:   decode = scrs_pkg::SEL_TX;
                `SCRS_IDX_CTRL_ONE: decode = scrs_pkg::SEL_CTRL;
                `SCRS_IDX_RX_BUF:   decode = scrs_pkg::SEL_RX;
                `SCRS_IDX_CLK_SRC:  decode = scrs_pkg::SEL_CLK_SRC;
                `SCRS_IDX_INT_STAT: decode = scrs_pkg::SEL_ISTAT;
                `SCRS_IDX_INT_MASK: decode = scrs_pkg::SEL_IMASK;
                default:            decode = scrs_pkg::SEL_NONE;
            endcase
        end
    endfunction

    // Framing and parity flags only live in the asynchronous modes
    function automatic logic async_mode(input logic [2:0] m);
        async_mode = (m == scrs_pkg::MODE_UART7) || (m == scrs_pkg::MODE_UART8)
                  || (m == scrs_pkg::MODE_UART9);
    endfunction

    // Character bits by length; unused bits drop out of the parity count
    function automatic logic [8:0] char_bits(input logic [2:0] m, input logic [8:0] c);
        case (m)
            scrs_pkg::MODE_UART7: char_bits = {2'h0, c[6:0]};
            scrs_pkg::MODE_UART8: char_bits = {1'h0, c[7:0]};
            default:              char_bits = c;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [1:0]  sda_sync_q, sda_sync_d;
    logic [7:0]  pclk_q, pclk_d;
    logic [7:0]  clk_src_q, clk_src_d;
    logic        wr_en_q, wr_en_d;
    logic [2:0]  mode_q, mode_d;
    logic        pry_q, pry_d;
    logic        re_q, re_d;
    logic        full_q, full_d;
    logic [8:0]  rx_data_q, rx_data_d;
    logic        abt_q, abt_d;
    logic        oer_q, oer_d;
    logic        fer_q, fer_d;
    logic        per_q, per_d;
    logic        tx_hi_q, tx_hi_d;
    logic [8:0]  tx_data_q, tx_data_d;
    logic        tx_load_q, tx_load_d;
    logic [`SCRS_NUM_INT-1:0] ist_q, ist_d;
    logic [`SCRS_NUM_INT-1:0] imask_q, imask_d;
    logic [31:0] rdata_q, rdata_d;

    scrs_pkg::scrs_sel_t sel;
    logic        wr_acc;
    logic        rd_acc;
    logic        setup;
    logic        rx_idle;
    logic        err_ok;
    logic        set_abt;
    logic        set_fer;
    logic        set_per;
    logic        set_oer;
    logic [15:0] rx_view;
    logic [`SCRS_NUM_INT-1:0] ev;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        sel     = decode(paddr);
        setup   = psel && !penable;
        wr_acc  = psel && penable && pwrite && (sel != scrs_pkg::SEL_NONE);
        rd_acc  = psel && penable && !pwrite && (sel != scrs_pkg::SEL_NONE);
        rx_idle = (mode_q == scrs_pkg::MODE_OFF) || !re_q;
        err_ok  = async_mode(mode_q);

        sda_sync_d = {sda_sync_q[0], sda_pin};
        pclk_d     = pclk_q;
        clk_src_d  = clk_src_q;
        wr_en_d    = wr_en_q;
        mode_d     = mode_q;
        pry_d      = pry_q;
        re_d       = re_q;
        full_d     = full_q;
        rx_data_d  = rx_data_q;
        abt_d      = abt_q;
        oer_d      = oer_q;
        fer_d      = fer_q;
        per_d      = per_q;
        tx_hi_d    = tx_hi_q;
        tx_data_d  = tx_data_q;
        tx_load_d  = 1'b0;
        imask_d    = imask_q;
        rdata_d    = rdata_q;

        // Events from the receiver and the bus data line
        set_oer = rx_done && full_q && !rx_idle;
        set_fer = rx_done && !rx_idle && err_ok && !rx_stop_ok;
        set_per = rx_done && !rx_idle && err_ok
               && ((^{char_bits(mode_q, rx_char), rx_parity_bit}) ^ !pry_q);
        set_abt = sda_sample && (mode_q == scrs_pkg::MODE_I2C)
               && (sda_sync_q[1] != sda_drive_level);

        // Register writes
        if (wr_acc) begin
            case (sel)
                scrs_pkg::SEL_PROTECT: begin
                    if (pstrb[0]) wr_en_d = pwdata[`SCRS_B_WR_EN];
                end
                scrs_pkg::SEL_PCLK: begin
                    if (pstrb[0] && wr_en_q) pclk_d = pwdata[7:0] & `SCRS_PCLK_WMASK;
                end
                scrs_pkg::SEL_CLK_SRC: begin
                    // Changing this mid-frame corrupts every channel's bit timing
                    if (pstrb[0]) clk_src_d = pwdata[7:0] & `SCRS_CLK_SRC_WMASK;
                end
                scrs_pkg::SEL_MODE: begin
                    if (pstrb[0]) begin
                        mode_d = pwdata[2:0];
                        pry_d  = pwdata[`SCRS_B_PARITY_SEL];
                    end
                end
                scrs_pkg::SEL_CTRL: begin
                    if (pstrb[0]) re_d = pwdata[`SCRS_B_RX_EN];
                end
                scrs_pkg::SEL_TX: begin
                    if (pstrb[1]) tx_hi_d = pwdata[8];
                    if (pstrb[0]) begin
                        tx_data_d = {pstrb[1] ? pwdata[8] : tx_hi_q, pwdata[7:0]};
                        tx_load_d = 1'b1;
                    end
                end
                scrs_pkg::SEL_RX: begin
                    if (pstrb[1] && !pwdata[`SCRS_B_ABT]) abt_d = 1'b0;
                end
                scrs_pkg::SEL_IMASK: begin
                    if (pstrb[0]) imask_d = pwdata[`SCRS_NUM_INT-1:0];
                end
                default: begin
                end
            endcase
        end

        // Any read of the receive buffer empties it and clears two flags
        if (rd_acc && sel == scrs_pkg::SEL_RX) begin
            fer_d  = 1'b0;
            per_d  = 1'b0;
            full_d = 1'b0;
        end

        // Transfer into the buffer; on overrun the data is simply overwritten
        if (rx_done && !rx_idle) begin
            rx_data_d = rx_char;
            full_d    = 1'b1;
        end
        if (set_oer) oer_d = 1'b1;
        if (set_fer) fer_d = 1'b1;
        if (set_per) per_d = 1'b1;
        if (set_abt) abt_d = 1'b1;

        // Disabled receiver wipes the overrun, framing and parity flags and the full bit; ABT is kept
        if (rx_idle) begin
            oer_d  = 1'b0;
            fer_d  = 1'b0;
            per_d  = 1'b0;
            full_d = 1'b0;
        end

        // Interrupt status: set wins over a write-one clear
        ev = '0;
        ev[`SCRS_I_RX]  = rx_done && !rx_idle;
        ev[`SCRS_I_OER] = set_oer;
        ev[`SCRS_I_FER] = set_fer;
        ev[`SCRS_I_PER] = set_per;
        ev[`SCRS_I_ABT] = set_abt;
        ist_d = ist_q;
        if (wr_acc && sel == scrs_pkg::SEL_ISTAT && pstrb[0]) begin
            ist_d = ist_q & ~pwdata[`SCRS_NUM_INT-1:0];
        end
        ist_d = ist_d | ev;

        // Read view of the receive buffer; inactive flags read as zero
        rx_view = 16'h0000;
        rx_view[8:0] = rx_data_q;
        rx_view[`SCRS_B_ABT] = abt_q;
        // Idle gating hides flags in the cycle before their clear lands
        rx_view[`SCRS_B_OER] = oer_q && !rx_idle;
        rx_view[`SCRS_B_FER] = fer_q && err_ok && !rx_idle;
        rx_view[`SCRS_B_PER] = per_q && err_ok && !rx_idle;
        rx_view[`SCRS_B_SUM] = (oer_q || fer_q || per_q) && err_ok && !rx_idle;

        // Read data is sampled in the setup cycle so it leaves a flip-flop
        if (setup) begin
            case (sel)
                scrs_pkg::SEL_PROTECT:  rdata_d = {31'h0, wr_en_q};
                scrs_pkg::SEL_PCLK:     rdata_d = {24'h0, pclk_q};
                scrs_pkg::SEL_CLK_SRC:  rdata_d = {24'h0, clk_src_q};
                scrs_pkg::SEL_MODE:     rdata_d = {25'h0, pry_q, 3'h0, mode_q};
                scrs_pkg::SEL_CTRL:     rdata_d = {28'h0, full_q, re_q, 2'h0};
                scrs_pkg::SEL_TX:       rdata_d = {23'h0, tx_data_q};
                scrs_pkg::SEL_RX:       rdata_d = {16'h0, rx_view};
                scrs_pkg::SEL_ISTAT:    rdata_d = {27'h0, ist_q};
                scrs_pkg::SEL_IMASK:    rdata_d = {27'h0, imask_q};
                default:                rdata_d = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_sync_q <= 2'h3;
            pclk_q     <= `SCRS_RST_PCLK_SEL;
            clk_src_q  <= `SCRS_RST_CLK_SRC;
            wr_en_q    <= 1'b0;
            mode_q     <= 3'h0;
            pry_q      <= 1'b0;
            re_q       <= 1'b0;
            full_q     <= 1'b0;
            rx_data_q  <= 9'h000;
            abt_q      <= 1'b0;
            oer_q      <= 1'b0;
            fer_q      <= 1'b0;
            per_q      <= 1'b0;
            tx_hi_q    <= 1'b0;
            tx_data_q  <= 9'h000;
            tx_load_q  <= 1'b0;
            ist_q      <= '0;
            imask_q    <= '0;
            rdata_q    <= 32'h0;
        end else if (ce) begin
            sda_sync_q <= sda_sync_d;
            pclk_q     <= pclk_d;
            clk_src_q  <= clk_src_d;
            wr_en_q    <= wr_en_d;
            mode_q     <= mode_d;
            pry_q      <= pry_d;
            re_q       <= re_d;
            full_q     <= full_d;
            rx_data_q  <= rx_data_d;
            abt_q      <= abt_d;
            oer_q      <= oer_d;
            fer_q      <= fer_d;
            per_q      <= per_d;
            tx_hi_q    <= tx_hi_d;
            tx_data_q  <= tx_data_d;
            tx_load_q  <= tx_load_d;
            ist_q      <= ist_d;
            imask_q    <= imask_d;
            rdata_q    <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // The bus waits while the block is frozen; writes are kept, but a read set up while frozen returns stale data
    assign pready  = ce;
    assign pslverr = psel && penable && (sel == scrs_pkg::SEL_NONE);
    assign prdata  = rdata_q;

    assign tx_data = tx_data_q;
    assign tx_load = tx_load_q;

    assign serial_clock_rate_sel          = pclk_q[`SCRS_B_SERIAL_RATE];
    assign timer_clock_rate_sel           = pclk_q[`SCRS_B_TIMER_RATE];
    assign clock_output_extension         = pclk_q[`SCRS_B_CLKOUT_EXT];
    assign low_channels_clock_source_sel  = clk_src_q[`SCRS_B_LOW_SRC];
    assign high_channels_clock_source_sel = clk_src_q[`SCRS_B_HIGH_SRC];
    assign mode_code                      = mode_q;
    assign reception_enable               = re_q;
    assign parity_odd_even_select         = pry_q;

    assign irq = |(ist_q & imask_q);

endmodule // scrs_core

/* test/scrs_core_asserts.sv */
// Concurrent checks on the ports of the serial clock select block
`timescale 1ns/100ps
`include "scrs_cfg.svh"

module scrs_core_asserts (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Register bus
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    // Transmit and controls
    input wire logic [8:0]  tx_data,
    input wire logic        tx_load,
    input wire logic        serial_clock_rate_sel,
    input wire logic        timer_clock_rate_sel,
    input wire logic [2:0]  mode_code,
    input wire logic        reception_enable
);
    logic [11:0] idx;
    logic        wr_acc, rd_setup, pclk_wr, prot_q, prot_d;
    assign idx      = paddr[13:2];
    assign wr_acc   = psel && penable && pwrite && ce;
    assign pclk_wr  = wr_acc && pstrb[0] && idx == `SCRS_IDX_PCLK_SEL;
    assign rd_setup = psel && !penable && !pwrite && ce && idx == `SCRS_IDX_RX_BUF;

    ////////////////////////////////////////////////////////////////////////////////
    // Protect bit is not a port, so it is shadowed from the bus writes
    always_comb begin
        prot_d = prot_q;
        if (wr_acc && pstrb[0] && idx == `SCRS_IDX_PROTECT) begin
            prot_d = pwdata[0];
        end
    end
    always_ff @(posedge sys_clk) begin
        prot_q <= rst ? 1'b0 : prot_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_reset_rates:
        assert property ($fell(rst) |-> serial_clock_rate_sel && timer_clock_rate_sel)
        else $error("Clock rate selects not at reset value");
    chk_pclk_locked:
        assert property (pclk_wr && !prot_q |=> $stable(serial_clock_rate_sel)
                         && $stable(timer_clock_rate_sel))
        else $error("Clock select changed while locked");
    chk_pclk_open:
        assert property (pclk_wr && prot_q |=> serial_clock_rate_sel == $past(pwdata[1])
                         && timer_clock_rate_sel == $past(pwdata[0]))
        else $error("Clock select write not taken");
    chk_sync_quiet:
        assert property (rd_setup && (mode_code == 3'h1 || mode_code == 3'h2)
                         |=> prdata[15:13] == 3'h0)
        else $error("Error flags active in synchronous or bus mode");
    chk_idle_clear:
        assert property (rd_setup && (mode_code == 3'h0 || !reception_enable)
                         |=> prdata[15:12] == 4'h0)
        else $error("Error flags set while receiver idle");
    chk_sum_any:
        assert property (rd_setup && mode_code[2] |=> prdata[15] == |prdata[14:12])
        else $error("Error sum disagrees with flags");
    chk_gap_zero:
        assert property (rd_setup |=> prdata[10:9] == 2'h0)
        else $error("Unimplemented receive bits not zero");
    chk_tx_low_load:
        assert property (tx_load |-> $past(wr_acc && pstrb[0] && idx == `SCRS_IDX_TX_BUF)
                         && tx_data[7:0] == $past(pwdata[7:0]))
        else $error("Transmit load without low byte write");

    cov_pclk_open: cover property (pclk_wr && prot_q);
    cov_tx_load: cover property (tx_load);
    cov_overrun: cover property (rd_setup && mode_code[2] ##1 prdata[12]);
endmodule // scrs_core_asserts

bind scrs_core scrs_core_asserts u_asserts (
    .sys_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .tx_data, .tx_load, .serial_clock_rate_sel, .timer_clock_rate_sel, .mode_code,
    .reception_enable
);

/* test/scrs_peer_model.sv */
// Model of the receive shift register and bus data line facing the block
`timescale 1ns/100ps

module scrs_peer_model (
    // Clock
    input  wire logic  sys_clk,
    // Receive shift register side
    output logic       rx_done,
    output logic [8:0] rx_char,
    output logic       rx_parity_bit,
    output logic       rx_stop_ok,
    // Bus-mode data line
    output logic       sda_pin,
    output logic       sda_drive_level,
    output logic       sda_sample
);
    initial begin
        rx_done = 1'b0;
        rx_char = 9'h000;
        rx_parity_bit = 1'b0;
        rx_stop_ok = 1'b0;
        sda_pin = 1'b1;
        sda_drive_level = 1'b1;
        sda_sample = 1'b0;
    end

    // Fields are inverted after the pulse so stale values are never mistaken for valid
    task automatic send_char(input logic [8:0] ch, input logic par, input logic stop);
        @(posedge sys_clk);
        rx_done       <= 1'b1;
        rx_char       <= ch;
        rx_parity_bit <= par;
        rx_stop_ok    <= stop;
        @(posedge sys_clk);
        rx_done       <= 1'b0;
        rx_char       <= ~ch;
        rx_parity_bit <= ~par;
        rx_stop_ok    <= ~stop;
    endtask

    // Line is pulled up; a low level here while drv is high means another master won the bit
    task automatic arb_bit(input logic pin, input logic drv);
        @(posedge sys_clk);
        sda_pin         <= pin;
        sda_drive_level <= drv;
        repeat (3) @(posedge sys_clk);
        sda_sample <= 1'b1;
        @(posedge sys_clk);
        sda_sample <= 1'b0;
        sda_pin    <= 1'b1;
    endtask
endmodule // scrs_peer_model

/* test/serial_clock_select_and_receive_status_bench.sv */
// Self-checking bench of the serial clock select and receive status block
`timescale 1ns/100ps
`include "scrs_cfg.svh"

module serial_clock_select_and_receive_status_bench;
    logic        sys_clk = 1'b0;
    logic        rst, ce, psel, penable, pwrite, pready, pslverr, rerr, irq, tx_load;
    logic [31:0] paddr, pwdata, prdata, rdata;
    logic [3:0]  pstrb;
    logic        rx_done, rx_parity_bit, rx_stop_ok, sda_pin, sda_drive_level, sda_sample;
    logic [8:0]  rx_char, tx_data, tx_last;
    logic        serial_clock_rate_sel, timer_clock_rate_sel, clock_output_extension;
    logic        low_channels_clock_source_sel, high_channels_clock_source_sel;
    logic        reception_enable, parity_odd_even_select;
    logic [2:0]  mode_code;
    int          num_errors = 0;
    int          comparisons = 0;
    int          tx_cnt = 0;

    always #50 sys_clk = ~sys_clk;

    scrs_core dut (.sys_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .rx_done, .rx_char, .rx_parity_bit, .rx_stop_ok,
        .sda_pin, .sda_drive_level, .sda_sample, .tx_data, .tx_load, .serial_clock_rate_sel,
        .timer_clock_rate_sel, .clock_output_extension, .low_channels_clock_source_sel,
        .high_channels_clock_source_sel, .mode_code, .reception_enable,
        .parity_odd_even_select, .irq);
    scrs_peer_model peer (.sys_clk, .rx_done, .rx_char, .rx_parity_bit, .rx_stop_ok,
        .sda_pin, .sda_drive_level, .sda_sample);

    always @(posedge sys_clk) begin
        if (tx_load === 1'b1) begin
            tx_cnt  <= tx_cnt + 1;
            tx_last <= tx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Request is held until pready is seen high, then released
    task automatic apb(input logic [11:0] idx, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {18'h0, idx, 2'h0};
        pwdata  <= d;
        pstrb   <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            wrap_up();
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Registered outputs settle before any caller looks at them
        @(negedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] s);
        apb(idx, 1'b1, d, s);
    endtask

    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] m, input logic [31:0] e);
        apb(idx, 1'b0, 32'h0, 4'h0);
        check(rdata & m, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        // Source bits go first, while every channel is still idle
        wr(`SCRS_IDX_CLK_SRC, 32'h0000000C, 4'h1);
        check(low_channels_clock_source_sel & high_channels_clock_source_sel, 1'b1);
        rd_chk(`SCRS_IDX_PCLK_SEL, 32'hFF, 32'h03);
        check(serial_clock_rate_sel, 1'b1);
        check(rerr, 1'b0);
        wr(`SCRS_IDX_PCLK_SEL, 32'h20, 4'h1);
        rd_chk(`SCRS_IDX_PCLK_SEL, 32'hFF, 32'h03);
        wr(`SCRS_IDX_PROTECT, 32'h01, 4'h1);
        wr(`SCRS_IDX_PCLK_SEL, 32'h20, 4'h1);
        rd_chk(`SCRS_IDX_PCLK_SEL, 32'hFF, 32'h20);
        check({serial_clock_rate_sel, timer_clock_rate_sel, clock_output_extension}, 3'h1);
        wr(`SCRS_IDX_PROTECT, 32'h00, 4'h1);
        apb(12'h100, 1'b0, 32'h0, 4'h0);
        check(rerr, 1'b1);
        // Even parity, eight bits; bad parity and missing stop bit
        wr(`SCRS_IDX_MODE, 32'h45, 4'h1);
        wr(`SCRS_IDX_CTRL_ONE, 32'h04, 4'h1);
        check({mode_code, parity_odd_even_select, reception_enable}, 5'h17);
        peer.send_char(9'h0A5, 1'b1, 1'b0);
        rd_chk(`SCRS_IDX_CTRL_ONE, 32'h0C, 32'h0C);
        rd_chk(`SCRS_IDX_INT_STAT, 32'h1F, 32'h0D);
        check(irq, 1'b0);
        wr(`SCRS_IDX_INT_MASK, 32'h04, 4'h1);
        #1 check(irq, 1'b1);
        wr(`SCRS_IDX_INT_STAT, 32'h04, 4'h1);
        #1 check(irq, 1'b0);
        rd_chk(`SCRS_IDX_INT_STAT, 32'h1F, 32'h09);
        rd_chk(`SCRS_IDX_RX_BUF, 32'hFFFF, 32'hE0A5);
        rd_chk(`SCRS_IDX_RX_BUF, 32'hFFFF, 32'h00A5);
        rd_chk(`SCRS_IDX_CTRL_ONE, 32'h0C, 32'h04);
        // Second character lands on a full buffer; data is then not compared
        peer.send_char(9'h03C, 1'b0, 1'b1);
        peer.send_char(9'h03C, 1'b0, 1'b1);
        rd_chk(`SCRS_IDX_RX_BUF, 32'hF800, 32'h9000);
        rd_chk(`SCRS_IDX_RX_BUF, 32'hF800, 32'h9000);
        wr(`SCRS_IDX_CTRL_ONE, 32'h00, 4'h1);
        rd_chk(`SCRS_IDX_RX_BUF, 32'hF800, 32'h0000);
        wr(`SCRS_IDX_CTRL_ONE, 32'h04, 4'h1);
        // Odd parity over 7, 8 and 9 bit characters of all ones
        for (int m = 4; m < 7; m++) begin
            wr(`SCRS_IDX_MODE, m, 4'h1);
            peer.send_char(9'h1FF, 1'b0, 1'b1);
            rd_chk(`SCRS_IDX_RX_BUF, 32'hF000, (m == 5) ? 32'hC000 : 32'h0);
        end
        wr(`SCRS_IDX_MODE, 32'h45, 4'h1);
        peer.send_char(9'h0A5, 1'b1, 1'b0);
        wr(`SCRS_IDX_MODE, 32'h00, 4'h1);
        rd_chk(`SCRS_IDX_RX_BUF, 32'hF000, 32'h0);
        wr(`SCRS_IDX_MODE, 32'h41, 4'h1);
        peer.send_char(9'h0A5, 1'b1, 1'b0);
        rd_chk(`SCRS_IDX_RX_BUF, 32'hE000, 32'h0);
        // Bus mode: a matching bit first, then a lost one
        wr(`SCRS_IDX_MODE, 32'h02, 4'h1);
        peer.arb_bit(1'b0, 1'b0);
        rd_chk(`SCRS_IDX_RX_BUF, 32'h0800, 32'h0);
        peer.arb_bit(1'b0, 1'b1);
        rd_chk(`SCRS_IDX_RX_BUF, 32'h0800, 32'h0800);
        wr(`SCRS_IDX_RX_BUF, 32'h0800, 4'h2);
        rd_chk(`SCRS_IDX_RX_BUF, 32'h0800, 32'h0800);
        wr(`SCRS_IDX_RX_BUF, 32'h0000, 4'h2);
        rd_chk(`SCRS_IDX_RX_BUF, 32'h0800, 32'h0);
        // Nine-bit transmit: high byte alone must not load
        wr(`SCRS_IDX_TX_BUF, 32'h0100, 4'h2);
        repeat (3) @(posedge sys_clk);
        check(tx_cnt, 0);
        wr(`SCRS_IDX_TX_BUF, 32'h005A, 4'h1);
        repeat (3) @(posedge sys_clk);
        check({tx_cnt[7:0], tx_last}, {8'h01, 9'h15A});
        wr(`SCRS_IDX_TX_BUF, 32'h00A3, 4'h3);
        repeat (3) @(posedge sys_clk);
        check({tx_cnt[7:0], tx_last}, {8'h02, 9'h0A3});
        wrap_up();
    end
endmodule // serial_clock_select_and_receive_status_bench
